// ==== dram_region_consts.svh ====
// Constants for the DRAM region boundary register bank
// Operation
// R01 - Upper usable top holds address bits 35:20 of top above 4 GB.
// R02 - Decode to DRAM when address is at/above 4 GB and below upper top.
// R03 - Boundary bits 19:0 are zero; 1 MB comparison resolution.
// R04 - Software sets upper top to memory top minus stolen when reclaim off.
// R05 - With reclaim on, software sets upper top to reclaim limit plus one.
// R06 - Upper top register is 16-bit read/write, reset value zero.
// R07 - Stolen base keeps bits 31:20; low 20 bits reserved, read zero.
// R08 - Software derives stolen base from low usable top minus stolen size.
// R09 - Stolen base writes ignored once the lock bit is set.
// R10 - Segment base keeps bits 31:20; low 20 bits reserved, read zero.
// R11 - Software derives segment base from stolen base minus segment size.
// R12 - Segment base writes ignored once the lock bit is set.
// R13 - Both 32-bit base registers reset to zero.
// R14 - Low usable top carries address bits 31:20 below 4 GB.
// R15 - Lock is sticky until device reset.
`ifndef DRAM_REGION_CONSTS_SVH
`define DRAM_REGION_CONSTS_SVH
`define OFF_UPPER_TOP    8'ha2
`define OFF_STOLEN_BASE  8'ha4
`define OFF_SEG_BASE     8'hac
`define UPPER_TOP_RESET  16'h0000
`define BASE_FIELD_RESET 12'h000
`define BASE_LSB         20
`define BASE_MSB         31
`define FOUR_GB_MB       16'h1000
`define ADDR_W           36
`define MB_LSB           20
`define ADDR_MSB         35
`endif

// ==== dram_region_pkg.sv ====
// Types for the DRAM region boundary register bank
package dram_region_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;
  typedef struct packed {
    logic        valid;
    logic [35:0] addr;
  } host_req_t;
endpackage

// ==== upper_decode.sv ====
// Upper DRAM window comparator
`timescale 1ns/1ps
`default_nettype none
`include "dram_region_consts.svh"
module upper_decode
  import dram_region_pkg::*;
(
  // Request and boundary
  input  wire host_req_t   req,
  input  wire logic [15:0] upper_top,
  // Decision
  output logic             hit
);
  logic [15:0] addr_mb;
  assign addr_mb = req.addr[`ADDR_MSB:`MB_LSB]; // R03
  assign hit = req.valid && (addr_mb >= `FOUR_GB_MB) && (addr_mb < upper_top); // R02
endmodule
`default_nettype wire

// ==== dram_region_boundary_regs.sv ====
// Lockable DRAM region boundary registers and upper window decode
`timescale 1ns/1ps
`default_nettype none
`include "dram_region_consts.svh"
module dram_region_boundary_regs
  import dram_region_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Configuration access
  input  wire cfg_req_t    cfg,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  // Memory controller side
  input  wire logic        smram_lock_set,
  input  wire logic [11:0] low_usable_top,
  // Host requests
  input  wire host_req_t   host_req,
  output logic             upper_dram_hit,
  // State
  output logic             smram_lock,
  output logic [15:0]      upper_usable_top,
  output logic [11:0]      stolen_base,
  output logic [11:0]      smm_segment_base_field
);
  logic rst_s1_q;
  logic rst_s2_q;
  logic lock_q;
  logic [15:0] top_q;
  logic [11:0] stolen_q;
  logic [11:0] seg_q;
  logic hit_d;
  logic hit_q;
  logic [31:0] rdata_d;

  // Reset released through two flops to avoid metastable release
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  function automatic logic hit_word(input cfg_req_t c, input logic [7:0] off);
    hit_word = c.wr && (c.addr == off);
  endfunction

  // Lock only clears at reset
  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      lock_q <= 1'b0;
    else if (smram_lock_set)
      lock_q <= 1'b1; // R15
  end

  // Upper top is not lockable here; byte lanes honoured
  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      top_q <= `UPPER_TOP_RESET; // R06
    else if (hit_word(cfg, `OFF_UPPER_TOP))
    begin
      if (cfg.be[0])
        top_q[7:0] <= cfg.wdata[7:0]; // R01
      if (cfg.be[1])
        top_q[15:8] <= cfg.wdata[15:8]; // R06
    end
  end

  // Writes under lock are dropped silently
  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      stolen_q <= `BASE_FIELD_RESET; // R13
    else if (hit_word(cfg, `OFF_STOLEN_BASE) && !lock_q) // R09
    begin
      if (cfg.be[2])
        stolen_q[3:0] <= cfg.wdata[23:20]; // R07
      if (cfg.be[3])
        stolen_q[11:4] <= cfg.wdata[31:24];
    end
  end

  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      seg_q <= `BASE_FIELD_RESET; // R13
    else if (hit_word(cfg, `OFF_SEG_BASE) && !lock_q) // R12
    begin
      if (cfg.be[2])
        seg_q[3:0] <= cfg.wdata[23:20]; // R10
      if (cfg.be[3])
        seg_q[11:4] <= cfg.wdata[31:24];
    end
  end

  // Read mux; reserved low bits and unmapped offsets read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (cfg.addr)
      `OFF_UPPER_TOP:   rdata_d = {16'h0000, top_q};
      `OFF_STOLEN_BASE: rdata_d = {stolen_q, 20'h00000}; // R07
      `OFF_SEG_BASE:    rdata_d = {seg_q, 20'h00000}; // R10
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rdata  <= cfg.rd ? rdata_d : 32'h0000_0000;
      cfg_rvalid <= cfg.rd;
    end
  end

  upper_decode u_dec (
    .req       (host_req),
    .upper_top (top_q),
    .hit       (hit_d)
  );

  // Registered decision costs one cycle but keeps the output a flop
  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      hit_q <= 1'b0;
    else
      hit_q <= hit_d; // R02
  end

  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      smram_lock             <= 1'b0;
      upper_usable_top       <= `UPPER_TOP_RESET;
      stolen_base            <= `BASE_FIELD_RESET;
      smm_segment_base_field <= `BASE_FIELD_RESET;
    end
    else
    begin
      smram_lock             <= lock_q;
      upper_usable_top       <= top_q;
      stolen_base            <= stolen_q;
      smm_segment_base_field <= seg_q;
    end
  end
  assign upper_dram_hit = hit_q;

  // low_usable_top is carried for software's stolen-base arithmetic only
  logic [11:0] low_top_unused;
  assign low_top_unused = low_usable_top; // R14

  a_lock_sticky: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    lock_q |=> lock_q) else $error("lock dropped"); // R15
  a_stolen_locked: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    lock_q |=> $stable(stolen_q)) else $error("stolen base changed under lock"); // R09
  a_seg_locked: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    lock_q |=> $stable(seg_q)) else $error("segment base changed under lock"); // R12
  a_top_write: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    hit_word(cfg, `OFF_UPPER_TOP) && cfg.be == 4'hf |=> top_q == $past(cfg.wdata[15:0]))
    else $error("upper top not written"); // R06
  a_hit_low: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    host_req.valid && host_req.addr[35:32] == 4'h0 |=> !upper_dram_hit)
    else $error("hit below 4 GB"); // R02
  a_hit_top: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    host_req.valid && host_req.addr[35:20] >= top_q |=> !upper_dram_hit)
    else $error("hit at or above top"); // R03
  a_stolen_read: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    cfg.rd && cfg.addr == `OFF_STOLEN_BASE |=> cfg_rvalid && cfg_rdata[19:0] == 20'h00000)
    else $error("stolen reserved bits set"); // R07
  a_seg_read: assert property (@(posedge mclk) disable iff (!rst_s2_q)
    cfg.rd && cfg.addr == `OFF_SEG_BASE |=> cfg_rdata == {$past(seg_q), 20'h00000})
    else $error("segment read wrong"); // R10
  a_reset_zero: assert property (@(posedge mclk)
    $rose(rst_s2_q) |-> stolen_q == 12'h000 && seg_q == 12'h000) else $error("base not reset"); // R13
  // Output copies trail the working registers by exactly one cycle
  a_top_copy: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R06
    upper_usable_top == $past(top_q))
    else $error("upper top output copy wrong");

  a_stolen_copy: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R07
    stolen_base == $past(stolen_q))
    else $error("stolen base output copy wrong");

  a_seg_copy: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R10
    smm_segment_base_field == $past(seg_q))
    else $error("segment base output copy wrong");

  a_lock_copy: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R15
    smram_lock == $past(lock_q))
    else $error("lock output copy wrong");

  // Read answer follows the read strobe one cycle later, for as many cycles as rd is held
  a_rvalid_rise: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R06
    cfg.rd |=> cfg_rvalid)
    else $error("read not answered");

  a_rvalid_idle: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R06
    !cfg.rd |=> !cfg_rvalid)
    else $error("read answer without request");

  a_idle_rdata: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R07
    !cfg.rd |=> cfg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");

  a_top_read: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R06
    cfg.rd && cfg.addr == `OFF_UPPER_TOP |=> cfg_rdata == {16'h0000, $past(top_q)})
    else $error("upper top read wrong");

  a_stolen_value: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R07
    cfg.rd && cfg.addr == `OFF_STOLEN_BASE |=> cfg_rdata[`BASE_MSB:`BASE_LSB] == $past(stolen_q))
    else $error("stolen base read wrong");

  a_seg_reserved: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R10
    cfg.rd && cfg.addr == `OFF_SEG_BASE |=> cfg_rdata[19:0] == 20'h00000)
    else $error("segment reserved bits set");

  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R07
    cfg.rd && cfg.addr != `OFF_UPPER_TOP && cfg.addr != `OFF_STOLEN_BASE && cfg.addr != `OFF_SEG_BASE
    |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Unlocked full writes land in the field
  a_stolen_write: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R07
    hit_word(cfg, `OFF_STOLEN_BASE) && !lock_q && cfg.be[3:2] == 2'b11 |=> stolen_q == $past(cfg.wdata[31:20]))
    else $error("stolen base not written");

  a_seg_write: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R10
    hit_word(cfg, `OFF_SEG_BASE) && !lock_q && cfg.be[3:2] == 2'b11 |=> seg_q == $past(cfg.wdata[31:20]))
    else $error("segment base not written");

  // Byte lanes touch only their own bits
  a_stolen_lane: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R07
    hit_word(cfg, `OFF_STOLEN_BASE) && !lock_q && cfg.be[3:2] == 2'b01
    |=> stolen_q[11:4] == $past(stolen_q[11:4]) && stolen_q[3:0] == $past(cfg.wdata[23:20]))
    else $error("stolen lane write wrong");

  a_seg_lane: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R10
    hit_word(cfg, `OFF_SEG_BASE) && !lock_q && cfg.be[3:2] == 2'b10
    |=> seg_q[3:0] == $past(seg_q[3:0]) && seg_q[11:4] == $past(cfg.wdata[31:24]))
    else $error("segment lane write wrong");

  a_top_lane: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R06
    hit_word(cfg, `OFF_UPPER_TOP) && cfg.be[1:0] == 2'b01
    |=> top_q[15:8] == $past(top_q[15:8]) && top_q[7:0] == $past(cfg.wdata[7:0]))
    else $error("upper top lane write wrong");

  a_top_nolane: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R06
    hit_word(cfg, `OFF_UPPER_TOP) && cfg.be[1:0] == 2'b00 |=> $stable(top_q))
    else $error("upper top changed without lanes");

  a_stolen_nolane: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R07
    hit_word(cfg, `OFF_STOLEN_BASE) && cfg.be[3:2] == 2'b00 |=> $stable(stolen_q))
    else $error("stolen base changed without lanes");

  a_seg_nolane: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R10
    hit_word(cfg, `OFF_SEG_BASE) && cfg.be[3:2] == 2'b00 |=> $stable(seg_q))
    else $error("segment base changed without lanes");

  // Fields only move on their own write
  a_top_hold: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R06
    !hit_word(cfg, `OFF_UPPER_TOP) |=> $stable(top_q))
    else $error("upper top changed unasked");

  a_stolen_hold: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R09
    !hit_word(cfg, `OFF_STOLEN_BASE) |=> $stable(stolen_q))
    else $error("stolen base changed unasked");

  a_seg_hold: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R12
    !hit_word(cfg, `OFF_SEG_BASE) |=> $stable(seg_q))
    else $error("segment base changed unasked");

  a_lock_take: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R15
    smram_lock_set |=> lock_q)
    else $error("lock not taken");

  a_lock_idle: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R15
    !smram_lock_set && !lock_q |=> !lock_q)
    else $error("lock set without request");

  // Window decode, both directions
  a_hit_in: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R02
    host_req.valid && host_req.addr[`ADDR_MSB:`MB_LSB] >= `FOUR_GB_MB
    && host_req.addr[`ADDR_MSB:`MB_LSB] < top_q |=> upper_dram_hit)
    else $error("hit missed inside window");

  a_hit_idle: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R02
    !host_req.valid |=> !upper_dram_hit)
    else $error("hit without request");

  a_hit_above: assert property (@(posedge mclk) disable iff (!rst_s2_q) // R02
    upper_dram_hit |-> $past(host_req.addr[`ADDR_MSB:`MB_LSB]) >= `FOUR_GB_MB)
    else $error("hit below window");

  c_top_read: cover property (@(posedge mclk) disable iff (!rst_s2_q)
    cfg.rd && cfg.addr == `OFF_UPPER_TOP);

  c_hit: cover property (@(posedge mclk) disable iff (!rst_s2_q) upper_dram_hit);
  c_lock: cover property (@(posedge mclk) disable iff (!rst_s2_q) $rose(lock_q));
  c_locked_wr: cover property (@(posedge mclk) disable iff (!rst_s2_q)
    lock_q && hit_word(cfg, `OFF_STOLEN_BASE));
endmodule
`default_nettype wire

// ==== host_master.sv ====
// Host request source for the upper window decode
`timescale 1ns/1ps
`default_nettype none
module host_master
  import dram_region_pkg::*;
(
  // Clock and command
  input  wire logic        mclk,
  input  wire logic        issue,
  input  wire logic [35:0] addr,
  // Request
  output var host_req_t    req
);
  // Idle address is inverted each cycle so a stale value never looks fresh
  always_ff @(posedge mclk)
  begin
    req.valid <= issue;
    req.addr  <= issue ? addr : ~req.addr;
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the DRAM region boundary registers
`timescale 1ns/1ps
`default_nettype none
module tb
  import dram_region_pkg::*;
;
  logic        mclk, rst_n, lock_set, issue, hit, lock, rvalid, hot, lk_m, exp_hit;
  logic [35:0] haddr;
  logic [31:0] rdata, seed, r;
  logic [11:0] low_top, stolen, seg, stl_m, seg_m;
  logic [15:0] top, top_m;
  cfg_req_t    cfg;
  host_req_t   hreq;
  int          bad_count, checks;
  logic [35:0] bnd [4] = '{36'h1_0400_0000, 36'h1_03ff_ffff, 36'h0_ffff_ffff, 36'h1_0000_0000};

  dram_region_boundary_regs u_dut (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .smram_lock_set(lock_set), .low_usable_top(low_top), .host_req(hreq),
    .upper_dram_hit(hit), .smram_lock(lock), .upper_usable_top(top), .stolen_base(stolen),
    .smm_segment_base_field(seg));
  host_master u_host (.mclk(mclk), .issue(issue), .addr(haddr), .req(hreq));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    {top_m, stl_m, seg_m, lk_m} = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic cw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    cfg <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(posedge mclk);
    cfg <= '0;
    if (a == 8'ha2) top_m = {be[1] ? d[15:8] : top_m[15:8], be[0] ? d[7:0] : top_m[7:0]};
    if (!lk_m && a == 8'ha4) stl_m = d[31:20];
    if (!lk_m && a == 8'hac) seg_m = d[31:20];
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    cfg <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0};
    @(posedge mclk);
    cfg <= '0;
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, e);
  endtask

  // Hit and its expectation both refer to the request of the previous edge
  always @(posedge mclk)
  begin
    exp_hit <= hreq.valid && hreq.addr >= 36'h1_0000_0000 && hreq.addr[35:20] < top_m;
    if (hot) chk(hit, exp_hit);
  end

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    end_sim();
  end

  initial
  begin
    {seed, rst_n, cfg, lock_set, issue, haddr, hot} = {32'h74f96ea5, 1'b0, 53'h0, 2'h0, 36'h0, 1'b0};
    low_top = 12'hecb;
    do_reset();
    cr(8'ha2, 32'h0);
    cr(8'ha4, 32'h0);
    cr(8'hac, 32'h0);
    cw(8'hb0, rnd(), 4'hf);
    cr(8'hb0, 32'h0);
    $display("reset values done");
    cw(8'ha2, 32'h0000_1040, 4'hf);
    cw(8'ha4, {low_top - 12'h002, 20'h5a5a5}, 4'hf);
    cw(8'hac, {low_top - 12'h003, 20'hfffff}, 4'hf);
    cr(8'ha4, {stl_m, 20'h0});
    cr(8'hac, {seg_m, 20'h0});
    chk(top, top_m);
    chk(stolen, stl_m);
    chk(seg, seg_m);
    $display("register access done");
    hot <= 1'b1;
    for (int i = 0; i < 200; i++)
    begin
      r = rnd();
      @(posedge mclk);
      issue <= i < 4 || r[30];
      haddr <= i < 4 ? bnd[i] : {3'h0, r[31], 6'h0, r[25:0]};
    end
    @(posedge mclk);
    issue <= 1'b0;
    repeat (3) @(posedge mclk);
    hot <= 1'b0;
    $display("host decode done");
    lock_set <= 1'b1;
    @(posedge mclk);
    lock_set <= 1'b0;
    lk_m = 1'b1;
    cw(8'ha4, 32'hfff0_0000, 4'hf);
    cw(8'hac, 32'hfff0_0000, 4'hf);
    cw(8'ha2, 32'h0000_2000, 4'h1);
    cr(8'ha4, {stl_m, 20'h0});
    cr(8'hac, {seg_m, 20'h0});
    cr(8'ha2, {16'h0, top_m});
    chk(lock, 1'b1);
    chk(stolen, stl_m);
    chk(seg, seg_m);
    $display("lock done");
    do_reset();
    cr(8'ha4, 32'h0);
    chk(lock, 1'b0);
    cw(8'ha2, 32'h0000_0fff, 4'h3);
    cr(8'ha2, {16'h0, top_m});
    $display("second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
